/* File: rpp_policy_model.sv */
// Behavioural receive policy: answers each packet start with a decision.
// Assumes the policy port's active-low rxp strobes; delay 0 answers promptly.
`timescale 1ns/100ps
`default_nettype none

module rpp_policy_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Stream from the device
  input wire logic rxpSof_b,
  input wire logic rxpAdvance_b,
  // Decision set by the bench
  input wire logic [3:0] cfgPort,
  input wire logic cfgRetry,
  input wire logic [3:0] cfgDelay,
  // Decision to the device
  output logic rxpRdy_b,
  output logic [3:0] rxpDemuxPort,
  output logic rxpForceRetry_b
);
  logic [3:0] waitCnt_r;
  logic sofSeen;

  assign sofSeen = !rxpSof_b && !rxpAdvance_b;

  // One cycle of header inspection, plus any extra delay
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      waitCnt_r <= 4'h0;
      rxpRdy_b <= 1'h1;
    end else begin
      rxpRdy_b <= !((sofSeen && cfgDelay == 4'h0) || waitCnt_r == 4'h1);
      if (sofSeen) begin
        waitCnt_r <= cfgDelay;
      end else if (waitCnt_r != 4'h0) begin
        waitCnt_r <= waitCnt_r - 4'h1;
      end
    end
  end

  // Port is only meaningful while ready is low; otherwise it shows junk
  assign rxpDemuxPort = rxpRdy_b ? ~cfgPort : cfgPort;
  assign rxpForceRetry_b = rxpRdy_b | ~cfgRetry;
endmodule : rpp_policy_model

`default_nettype wire

/* File: rpp_policy_pkg.sv */
// Types for the receive policy port.
// Assumes rpp_policy_regs.svh is compiled alongside.
package rpp_policy_pkg;

  // Packet handling phases
  typedef enum logic [1:0] {
    RPP_IDLE,
    RPP_DECIDE,
    RPP_HEAD,
    RPP_STREAM
  } rpp_state_type;

endpackage : rpp_policy_pkg

/* File: rpp_policy_port.sv */
// Receive policy port: streams packets to a user policy, applies its decision.
// Assumes one clock, well framed input packets and a policy that answers once.
`timescale 1ns/100ps
`default_nettype none
`include "rpp_policy_regs.svh"

module rpp_policy_port (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Incoming packet stream from the link
  input wire logic [`RPP_BEAT_W-1:0] inBeat,
  input wire logic inValid,
  input wire logic inEof,
  input wire logic inCrcErr,
  output logic inReady,
  // Port state from the physical layer
  input wire logic portInRetry,
  input wire logic portInError,
  // Policy side
  output logic [`RPP_BEAT_W-1:0] rxpData,
  output logic rxpSof_b,
  output logic rxpEof_b,
  output logic rxpAdvance_b,
  output logic rxpDiscard_b,
  input wire logic rxpRdy_b,
  input wire logic [`RPP_PORT_W-1:0] rxpDemuxPort,
  input wire logic rxpForceRetry_b,
  // Logical port side
  output logic [`RPP_BEAT_W-1:0] lpData,
  output logic [`RPP_PORT_W-1:0] lpPort,
  output logic lpValid,
  output logic lpSof,
  output logic lpEof,
  output logic lpAbort,
  input wire logic lpReady,
  // Per packet result pulses
  output logic pktAccept,
  output logic pktRetry
);

  rpp_policy_pkg::rpp_state_type state_r;

  logic [`RPP_ENTRY_W-1:0] bufMem [`RPP_BUF_DEPTH];
  logic wrPtr_r;
  logic rdPtr_r;
  logic [1:0] count_r;
  logic [1:0] countNxt;
  logic bufValid;
  logic bufPop;
  logic bufPush;
  logic [`RPP_ENTRY_W-1:0] head;
  logic headEof;

  logic [`RPP_BEAT_W-1:0] hold_r;
  logic single_r;
  logic bad_r;
  logic drop_r;
  logic retryReq_r;
  logic [`RPP_PORT_W-1:0] destPort_r;
  logic outFree;
  logic lpLoad;
  logic endPkt;
  logic endBad;

  // A packet must be discarded on CRC error or a bad input state
  function automatic logic discardCause(input logic crc, input logic retrySt,
                                        input logic errSt, input logic seen);
    discardCause = crc | retrySt | errSt | seen;
  endfunction : discardCause

  // Two-entry skid buffer between the link and the policy logic
  assign bufValid = (count_r != 2'h0);
  assign bufPush = inValid & inReady;
  assign head = bufMem[rdPtr_r];
  assign headEof = head[`RPP_ENTRY_EOF];
  assign outFree = ~lpValid | lpReady;

  always_comb begin
    bufPop = 1'b0;
    unique case (state_r)
      rpp_policy_pkg::RPP_IDLE: bufPop = bufValid;
      rpp_policy_pkg::RPP_STREAM: bufPop = bufValid & (drop_r | outFree);
      default: bufPop = 1'b0;
    endcase
  end

  always_comb begin
    countNxt = count_r;
    if (bufPush & ~bufPop) begin
      countNxt = count_r + 2'h1;
    end else if (bufPop & ~bufPush) begin
      countNxt = count_r - 2'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_r <= 1'b0;
      rdPtr_r <= 1'b0;
      count_r <= 2'h0;
      inReady <= 1'b0;
    end else begin
      if (bufPush) begin
        wrPtr_r <= ~wrPtr_r;
      end
      if (bufPop) begin
        rdPtr_r <= ~rdPtr_r;
      end
      count_r <= countNxt;
      inReady <= (countNxt != 2'h2);
    end
  end

  always_ff @(posedge clock) begin
    if (bufPush) begin
      bufMem[wrPtr_r] <= {inCrcErr, inEof, inBeat};
    end
  end

  // Packet ends on the popped end beat, or in the head phase of a one-beat packet
  // Discard history of a finished packet must not leak into the next one's first beat
  assign endBad = discardCause(head[`RPP_ENTRY_CRC], portInRetry, portInError,
                               bad_r & (state_r != rpp_policy_pkg::RPP_IDLE));
  assign endPkt = (state_r == rpp_policy_pkg::RPP_STREAM && bufPop && headEof) ||
                  (state_r == rpp_policy_pkg::RPP_HEAD && single_r && (drop_r || outFree));
  assign lpLoad = (state_r == rpp_policy_pkg::RPP_HEAD && !drop_r && outFree) ||
                  (state_r == rpp_policy_pkg::RPP_STREAM && bufPop && !drop_r);

  // Sequencing of one packet
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= rpp_policy_pkg::RPP_IDLE;
    end else begin
      unique case (state_r)
        rpp_policy_pkg::RPP_IDLE: begin
          if (bufPop) begin
            state_r <= rpp_policy_pkg::RPP_DECIDE;
          end
        end
        rpp_policy_pkg::RPP_DECIDE: begin
          if (!rxpRdy_b) begin
            state_r <= rpp_policy_pkg::RPP_HEAD;
          end
        end
        rpp_policy_pkg::RPP_HEAD: begin
          if (drop_r || outFree) begin
            state_r <= single_r ? rpp_policy_pkg::RPP_IDLE : rpp_policy_pkg::RPP_STREAM;
          end
        end
        rpp_policy_pkg::RPP_STREAM: begin
          if (endPkt) begin
            state_r <= rpp_policy_pkg::RPP_IDLE;
          end
        end
      endcase
    end
  end

  // Header hold, discard tracking and the sampled policy decision
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      hold_r <= 64'h0;
      single_r <= 1'b0;
      bad_r <= 1'b0;
      drop_r <= 1'b0;
      retryReq_r <= 1'b0;
      destPort_r <= 4'h0;
    end else begin
      if (state_r == rpp_policy_pkg::RPP_IDLE && bufPop) begin
        hold_r <= head[`RPP_BEAT_W-1:0];
        single_r <= headEof;
        bad_r <= endBad;
      end else if (state_r != rpp_policy_pkg::RPP_IDLE) begin
        bad_r <= bad_r | portInRetry | portInError;
      end
      if (state_r == rpp_policy_pkg::RPP_DECIDE && !rxpRdy_b) begin
        destPort_r <= rxpDemuxPort;
        retryReq_r <= ~rxpForceRetry_b;
        drop_r <= ~rxpForceRetry_b | bad_r | portInRetry | portInError;
      end
    end
  end

  // Beats shown to the policy, one advance per popped beat
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rxpData <= 64'h0;
      rxpSof_b <= `RPP_NEG_IDLE;
      rxpEof_b <= `RPP_NEG_IDLE;
      rxpAdvance_b <= `RPP_NEG_IDLE;
      rxpDiscard_b <= `RPP_NEG_IDLE;
    end else begin
      rxpSof_b <= `RPP_NEG_IDLE;
      rxpEof_b <= `RPP_NEG_IDLE;
      rxpAdvance_b <= `RPP_NEG_IDLE;
      rxpDiscard_b <= `RPP_NEG_IDLE;
      if (bufPop) begin
        rxpData <= head[`RPP_BEAT_W-1:0];
        rxpAdvance_b <= `RPP_NEG_ACT;
        if (state_r == rpp_policy_pkg::RPP_IDLE) begin
          rxpSof_b <= `RPP_NEG_ACT;
        end
        if (headEof) begin
          rxpEof_b <= `RPP_NEG_ACT;
          rxpDiscard_b <= endBad ? `RPP_NEG_ACT : `RPP_NEG_IDLE;
        end
      end
    end
  end

  // Forwarding to the chosen logical port, held until taken
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      lpData <= 64'h0;
      lpPort <= 4'h0;
      lpValid <= 1'b0;
      lpSof <= 1'b0;
      lpEof <= 1'b0;
      lpAbort <= 1'b0;
    end else begin
      if (lpLoad) begin
        lpValid <= 1'b1;
        lpPort <= destPort_r;
        if (state_r == rpp_policy_pkg::RPP_HEAD) begin
          lpData <= hold_r;
          lpSof <= 1'b1;
          lpEof <= single_r;
          lpAbort <= 1'b0;
        end else begin
          lpData <= head[`RPP_BEAT_W-1:0];
          lpSof <= 1'b0;
          lpEof <= headEof;
          lpAbort <= headEof & endBad;
        end
      end else if (lpReady) begin
        lpValid <= 1'b0;
      end
    end
  end

  // One pulse per packet: accepted, or dropped or aborted for retry
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pktAccept <= 1'b0;
      pktRetry <= 1'b0;
    end else begin
      pktAccept <= 1'b0;
      pktRetry <= 1'b0;
      if (endPkt) begin
        if (drop_r || retryReq_r || (state_r == rpp_policy_pkg::RPP_STREAM && endBad)) begin
          pktRetry <= 1'b1;
        end else begin
          pktAccept <= 1'b1;
        end
      end
    end
  end

  AST_ADV_VALID: assert property (@(posedge clock) disable iff (!rst_b)
    !rxpAdvance_b |-> $past(bufValid))
    else $error("advance without a buffered beat");

  AST_DATA_BEAT: assert property (@(posedge clock) disable iff (!rst_b)
    bufPop |=> rxpData == $past(head[`RPP_BEAT_W-1:0]))
    else $error("policy beat differs from the popped beat");

  AST_SOF_FIRST: assert property (@(posedge clock) disable iff (!rst_b)
    (bufPop && state_r == rpp_policy_pkg::RPP_IDLE) |=> !rxpSof_b && !rxpAdvance_b)
    else $error("first beat shown without start marker");

  AST_EOF_LAST: assert property (@(posedge clock) disable iff (!rst_b)
    (bufPop && headEof) |=> !rxpEof_b && !rxpAdvance_b)
    else $error("last beat shown without end marker");

  AST_DISCARD_EOF: assert property (@(posedge clock) disable iff (!rst_b)
    !rxpDiscard_b |-> !rxpEof_b)
    else $error("discard marker without end marker");

  AST_DISCARD_STATE: assert property (@(posedge clock) disable iff (!rst_b)
    (bufPop && headEof && (portInError || head[`RPP_ENTRY_CRC])) |=> !rxpDiscard_b)
    else $error("bad packet not marked for discard");

  AST_DISCARD_RETRY: assert property (@(posedge clock) disable iff (!rst_b)
    (!rxpDiscard_b && state_r == rpp_policy_pkg::RPP_IDLE) |-> ##[0:3] pktRetry)
    else $error("discarded packet not retried");

  AST_PORT_SAMPLE: assert property (@(posedge clock) disable iff (!rst_b)
    (state_r == rpp_policy_pkg::RPP_DECIDE && !rxpRdy_b) |=> destPort_r == $past(rxpDemuxPort))
    else $error("destination not sampled with ready");

  AST_NO_EARLY_FWD: assert property (@(posedge clock) disable iff (!rst_b)
    (state_r == rpp_policy_pkg::RPP_DECIDE) |=> !$rose(lpValid))
    else $error("beat forwarded before policy decision");

  AST_LP_ROUTE: assert property (@(posedge clock) disable iff (!rst_b)
    (state_r == rpp_policy_pkg::RPP_HEAD && !drop_r && outFree)
      |=> lpValid && lpSof && lpPort == $past(destPort_r))
    else $error("accepted packet head not forwarded to the chosen port");

endmodule : rpp_policy_port
`default_nettype wire

/* File: rpp_policy_regs.svh */
// Constants for the receive policy port: widths, depths and polarities.
// Assumes inclusion by the policy port design module only.
`ifndef RPP_POLICY_REGS_SVH
`define RPP_POLICY_REGS_SVH

// Beat width of the packet stream
`define RPP_BEAT_W 64
// Width of the logical port number from the policy
`define RPP_PORT_W 4
// Entries in the input skid buffer
`define RPP_BUF_DEPTH 2
// Entry width: beat, end-of-packet flag, CRC error flag
`define RPP_ENTRY_W 66
// Bit positions inside a buffer entry
`define RPP_ENTRY_EOF 64
`define RPP_ENTRY_CRC 65
// Idle and active levels of the active-low policy strobes
`define RPP_NEG_IDLE 1'h1
`define RPP_NEG_ACT 1'h0

`endif

/* File: tb_rpp_policy_port.sv */
// Self-checking bench for the receive policy port.
// Assumes rpp_policy_model as the policy and the bench as link and logical port.
`timescale 1ns/100ps
`default_nettype none

module tb_rpp_policy_port;
  logic clock, rst_b, inValid, inEof, inCrcErr, inReady, portInRetry, portInError;
  logic [63:0] inBeat, rxpData, lpData, firstData;
  logic rxpSof_b, rxpEof_b, rxpAdvance_b, rxpDiscard_b, rxpRdy_b, rxpForceRetry_b;
  logic [3:0] rxpDemuxPort, lpPort, polPort, polDelay, portSeen;
  logic lpValid, lpSof, lpEof, lpAbort, lpReady, pktAccept, pktRetry, polRetry, stall;
  int failures, comparisons, nAdv, nSof, nEof, nDisc, nAcc, nRet, nLps, nLpe, nAbt;
  logic [63:0] lpq[$];
  logic [63:0] rxq[$];

  rpp_policy_port i_dut (.clock(clock), .rst_b(rst_b), .inBeat(inBeat), .inValid(inValid),
    .inEof(inEof), .inCrcErr(inCrcErr), .inReady(inReady), .portInRetry(portInRetry),
    .portInError(portInError), .rxpData(rxpData), .rxpSof_b(rxpSof_b), .rxpEof_b(rxpEof_b),
    .rxpAdvance_b(rxpAdvance_b), .rxpDiscard_b(rxpDiscard_b), .rxpRdy_b(rxpRdy_b),
    .rxpDemuxPort(rxpDemuxPort), .rxpForceRetry_b(rxpForceRetry_b), .lpData(lpData),
    .lpPort(lpPort), .lpValid(lpValid), .lpSof(lpSof), .lpEof(lpEof), .lpAbort(lpAbort),
    .lpReady(lpReady), .pktAccept(pktAccept), .pktRetry(pktRetry));

  rpp_policy_model i_pol (.clock(clock), .rst_b(rst_b), .rxpSof_b(rxpSof_b),
    .rxpAdvance_b(rxpAdvance_b), .cfgPort(polPort), .cfgRetry(polRetry), .cfgDelay(polDelay),
    .rxpRdy_b(rxpRdy_b), .rxpDemuxPort(rxpDemuxPort), .rxpForceRetry_b(rxpForceRetry_b));

  initial begin
    clock = 1'h0;
    forever #20 clock = ~clock;
  end

  // Logical port stalls every other cycle when asked
  always @(posedge clock) lpReady <= stall ? ~lpReady : 1'h1;

  // Event counters on the design's outputs
  always @(posedge clock) begin
    if (!rxpAdvance_b) begin
      nAdv++;
      rxq.push_back(rxpData);
    end
    if (!rxpSof_b && !rxpAdvance_b) begin
      nSof++;
      firstData = rxpData;
    end
    if (!rxpEof_b && !rxpAdvance_b) nEof++;
    if (!rxpDiscard_b) nDisc += rxpEof_b ? 100 : 1;
    if (lpValid && lpReady) begin
      lpq.push_back(lpData);
      portSeen = lpPort;
      nLps += lpSof;
      nLpe += lpEof;
      nAbt += lpAbort;
    end
    if (pktAccept) nAcc++;
    if (pktRetry) nRet++;
  end

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic stop_test();
    if (failures == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test

  // Sends one packet and judges everything it produced; fwd: beats reach the logical port
  task automatic pkt(input int n, input logic crc, input logic [1:0] st, input logic acc,
                     input logic fwd);
    int a0, s0, e0, d0, c0, r0, ls0, le0, ab0, w;
    logic [63:0] base;
    base = 64'hC0DE000000000000 | (64'(n) << 16);
    lpq.delete();
    rxq.delete();
    a0 = nAdv;
    s0 = nSof;
    e0 = nEof;
    d0 = nDisc;
    c0 = nAcc;
    r0 = nRet;
    ls0 = nLps;
    le0 = nLpe;
    ab0 = nAbt;
    portInRetry <= st[0];
    portInError <= st[1];
    for (int i = 0; i < n; i++) begin
      inBeat <= base + 64'(i);
      inValid <= 1'h1;
      inEof <= (i == n - 1);
      inCrcErr <= crc && (i == n - 1);
      do @(posedge clock); while (!inReady);
    end
    inValid <= 1'h0;
    portInRetry <= 1'h0;
    portInError <= 1'h0;
    w = 0;
    while (nAcc + nRet == c0 + r0 && w < 200) begin
      @(posedge clock);
      w++;
    end
    repeat (4) @(posedge clock);
    chk("advance", n, nAdv - a0);
    chk("sof", 1, nSof - s0);
    chk("firstData", base, firstData);
    foreach (rxq[i]) chk("rxpData", base + 64'(i), rxq[i]);
    chk("eof", 1, nEof - e0);
    chk("discard", crc || st != 2'h0, nDisc - d0);
    chk("accept", acc, nAcc - c0);
    chk("retry", !acc, nRet - r0);
    chk("lpBeats", fwd ? n : 0, lpq.size());
    foreach (lpq[i]) chk("lpData", base + 64'(i), lpq[i]);
    chk("lpSof", fwd, nLps - ls0);
    chk("lpEof", fwd, nLpe - le0);
    chk("lpAbort", fwd && !acc, nAbt - ab0);
    if (fwd) chk("lpPort", polPort, portSeen);
  endtask : pkt

  task automatic test_accept();
    polPort <= 4'h5;
    stall <= 1'h1;
    pkt(6, 1'h0, 2'h0, 1'h1, 1'h1);
    stall <= 1'h0;
  endtask : test_accept

  task automatic test_force_retry();
    polRetry <= 1'h1;
    polDelay <= 4'h2;
    pkt(3, 1'h0, 2'h0, 1'h0, 1'h0);
    polRetry <= 1'h0;
    polDelay <= 4'h0;
  endtask : test_force_retry

  task automatic test_crc_drop();
    polPort <= 4'hA;
    pkt(1, 1'h1, 2'h0, 1'h0, 1'h0);
    pkt(3, 1'h1, 2'h0, 1'h0, 1'h1);
  endtask : test_crc_drop

  task automatic test_port_state();
    polDelay <= 4'h3;
    pkt(2, 1'h0, 2'h1, 1'h0, 1'h0);
    pkt(2, 1'h0, 2'h2, 1'h0, 1'h0);
    polDelay <= 4'h0;
    pkt(1, 1'h0, 2'h0, 1'h1, 1'h1);
  endtask : test_port_state

  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    stop_test();
  end

  initial begin
    rst_b = 1'h0;
    inBeat = 64'h0;
    {inValid, inEof, inCrcErr, portInRetry, portInError, stall, polRetry} = 7'h0;
    polPort = 4'h0;
    polDelay = 4'h0;
    repeat (20) @(posedge clock);
    rst_b <= 1'h1;
    repeat (2) @(posedge clock);
    test_accept();
    test_force_retry();
    test_crc_drop();
    test_port_state();
    stop_test();
  end
endmodule : tb_rpp_policy_port

`default_nettype wire
